// ===== csc_check_sva.sv
// Port-level assertions for the command source combiner
`timescale 1ns/100ps
`default_nettype none
module csc_check_sva (
  // Clock, reset, register port
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  // Serial side and terminals
  input wire logic [15:0] ser_word_in,
  input wire logic        ser_word_stb_in,
  input wire logic        ser_baud_wr_in,
  input wire logic        term_coast_n_in,
  input wire logic        term_qstop_n_in,
  input wire logic        term_dcbrake_n_in,
  input wire logic        term_start_in,
  input wire logic        term_reverse_in,
  // Resolved commands and bit-rate selection
  input wire logic        coast_req_out,
  input wire logic        qstop_req_out,
  input wire logic        dcbrake_req_out,
  input wire logic        start_req_out,
  input wire logic        reverse_req_out,
  input wire logic [2:0]  baud_sel_out
);
  // Shadow state rebuilt from port traffic only
  reg [9:0]  sel_q;
  reg [15:0] cw_q;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sel_q <= 10'h3FF;
      cw_q  <= 16'h001C;
    end else begin
      if (reg_wr_in && reg_addr_in == 4'h0) sel_q <= reg_wdata_in[9:0];
      if (ser_word_stb_in && ser_word_in[10]) cw_q <= ser_word_in;
    end
  end
  // Both sources already turned active high
  function automatic logic rs(input logic [1:0] m, input logic a, input logic b);
    rs = m[1] ? (m[0] ? a | b : a & b) : (m[0] ? b : a);
  endfunction
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_coast_cmd: assert property ($past(reset_n_in) |-> coast_req_out ==
    $past(rs(sel_q[1:0], !term_coast_n_in, !cw_q[3]))) else $error("coast wrong");
  a_stop_brake: assert property ($past(reset_n_in) |->
    {qstop_req_out, dcbrake_req_out} == $past({rs(sel_q[3:2], !term_qstop_n_in, !cw_q[4]),
    rs(sel_q[5:4], !term_dcbrake_n_in, !cw_q[2])})) else $error("stop or brake wrong");
  a_start_cmd: assert property ($past(reset_n_in) |-> start_req_out ==
    $past(rs(sel_q[7:6], term_start_in, cw_q[6]))) else $error("start wrong");
  a_reverse_cmd: assert property ($past(reset_n_in) |-> reverse_req_out ==
    $past(rs(sel_q[9:8], term_reverse_in, cw_q[15]))) else $error("reverse wrong");
  a_reset_idle: assert property ($rose(reset_n_in) |-> baud_sel_out == 3'h5 &&
    !(coast_req_out | qstop_req_out | dcbrake_req_out | start_req_out | reverse_req_out))
    else $error("reset state wrong");
  a_word_read: assert property (reg_rd_in && reg_addr_in == 4'h1 |=>
    reg_rdata_out == $past(cw_q)) else $error("word readback wrong");
  a_sel_read: assert property (reg_rd_in && reg_addr_in == 4'h0 |=>
    reg_rdata_out[9:0] == $past(sel_q)) else $error("selector readback wrong");
  a_baud_refuse: assert property (ser_baud_wr_in && !reg_wr_in |=>
    $stable(baud_sel_out)) else $error("link changed bit rate");
  cover property (sel_q == 10'h2AA && coast_req_out);
  cover property (sel_q == 10'h155 && start_req_out);
  cover property (ser_baud_wr_in);
endmodule // csc_check_sva
bind csc_combiner csc_check_sva i_csc_check_sva (.*);
`default_nettype wire

// ===== csc_combiner.v
// Command source combiner: selectors, serial word latch, resolved commands
`timescale 1ns/100ps
`default_nettype none

module csc_combiner (
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_n_in,
  // Local register port
  input  wire [3:0]  reg_addr_in,
  input  wire [15:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [15:0] reg_rdata_out,
  // Serial control word from the bus master
  input  wire [15:0] ser_word_in,
  input  wire        ser_word_stb_in,
  // Bit-rate write attempt arriving over the serial link
  input  wire        ser_baud_wr_in,
  // Terminal inputs
  input  wire        term_coast_n_in,
  input  wire        term_qstop_n_in,
  input  wire        term_dcbrake_n_in,
  input  wire        term_start_in,
  input  wire        term_reverse_in,
  // Resolved commands, active high
  output reg         coast_req_out,
  output reg         qstop_req_out,
  output reg         dcbrake_req_out,
  output reg         start_req_out,
  output reg         reverse_req_out,
  // Bit-rate selection for the serial link
  output reg  [2:0]  baud_sel_out
);

`include "csc_defines.vh"

  reg  [9:0]  src_sel_q;
  reg  [15:0] ctl_word_q;
  reg  [2:0]  baud_q;
  reg         reject_q;
  reg  [15:0] word_cnt_q;
  reg  [15:0] drop_cnt_q;
  reg  [4:0]  cmd_q;
  reg  [15:0] rdata_d;

  wire [4:0]  term_vec;
  wire [4:0]  ser_vec;
  wire [4:0]  req_vec;
  wire        word_ok;
  wire        word_bad;
  wire        sel_wr;
  wire        baud_wr;
  wire        status_wr;
  wire        reject_clr;

  // Source gathering per command slot
  assign term_vec[`CSC_CMD_COAST]   = term_coast_n_in;
  assign term_vec[`CSC_CMD_QSTOP]   = term_qstop_n_in;
  assign term_vec[`CSC_CMD_DCBRAKE] = term_dcbrake_n_in;
  assign term_vec[`CSC_CMD_START]   = term_start_in;
  assign term_vec[`CSC_CMD_REVERSE] = term_reverse_in;

  assign ser_vec[`CSC_CMD_COAST]   = ctl_word_q[`CSC_CW_COAST_BIT];
  assign ser_vec[`CSC_CMD_QSTOP]   = ctl_word_q[`CSC_CW_QSTOP_BIT];
  assign ser_vec[`CSC_CMD_DCBRAKE] = ctl_word_q[`CSC_CW_DCBRAKE_BIT];
  assign ser_vec[`CSC_CMD_START]   = ctl_word_q[`CSC_CW_START_BIT];
  assign ser_vec[`CSC_CMD_REVERSE] = ctl_word_q[`CSC_CW_REVERSE_BIT];

  // Local write decode
  assign sel_wr     = reg_wr_in && (reg_addr_in == `CSC_REG_SRC_SEL);
  assign baud_wr    = reg_wr_in && (reg_addr_in == `CSC_REG_BAUD);
  assign status_wr  = reg_wr_in && (reg_addr_in == `CSC_REG_STATUS);
  assign reject_clr = status_wr && reg_wdata_in[`CSC_ST_REJECT_BIT];

  // Only words flagged valid replace the latched serial bits
  assign word_ok  = ser_word_stb_in && ser_word_in[`CSC_CW_VALID_BIT];
  assign word_bad = ser_word_stb_in && !ser_word_in[`CSC_CW_VALID_BIT];

  // One combiner per command
  genvar g;
  generate
    for (g = 0; g < `CSC_NUM_CMD; g = g + 1) begin : g_cmd
      csc_source_mux #(
        .ACT_LOW (((`CSC_ACT_LOW_MASK >> g) & 1) != 0)
      ) u_mux (
        .sel_in  (src_sel_q[2*g+1:2*g]),
        .term_in (term_vec[g]),
        .ser_in  (ser_vec[g]),
        .req_out (req_vec[g])
      );
    end
  endgenerate

  // Source selectors, OR combination after reset
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_sel_q <= `CSC_SRC_SEL_RST;
    end else if (sel_wr) begin
      src_sel_q <= reg_wdata_in[9:0];
    end
  end

  // Latched serial control word
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_word_q <= `CSC_CW_RST;
    end else if (word_ok) begin
      ctl_word_q <= ser_word_in;
    end
  end

  // Bit rate: local port only; out-of-range values ignored
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      baud_q <= `CSC_BAUD_RST;
    end else if (baud_wr && (reg_wdata_in[2:0] <= `CSC_BAUD_MAX)) begin
      baud_q <= reg_wdata_in[2:0];
    end
  end

  // Sticky flag for a refused serial bit-rate change; set wins over clear
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reject_q <= 1'b0;
    end else if (ser_baud_wr_in) begin
      reject_q <= 1'b1;
    end else if (reject_clr) begin
      reject_q <= 1'b0;
    end
  end

  // Word counters wrap, for link health checks
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      word_cnt_q <= 16'h0000;
      drop_cnt_q <= 16'h0000;
    end else begin
      if (word_ok) begin
        word_cnt_q <= word_cnt_q + 16'h0001;
      end
      if (word_bad) begin
        drop_cnt_q <= drop_cnt_q + 16'h0001;
      end
    end
  end

  // Registered commands; reset state is serial-inactive under OR
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_q <= 5'h00;
    end else begin
      cmd_q <= req_vec;
    end
  end

  always @* begin
    coast_req_out   = cmd_q[`CSC_CMD_COAST];
    qstop_req_out   = cmd_q[`CSC_CMD_QSTOP];
    dcbrake_req_out = cmd_q[`CSC_CMD_DCBRAKE];
    start_req_out   = cmd_q[`CSC_CMD_START];
    reverse_req_out = cmd_q[`CSC_CMD_REVERSE];
    baud_sel_out    = baud_q;
  end

  // Read mux; unmapped reads give zero
  always @* begin
    rdata_d = 16'h0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `CSC_REG_SRC_SEL:  rdata_d = {6'h00, src_sel_q};
        `CSC_REG_CTL_WORD: rdata_d = ctl_word_q;
        `CSC_REG_BAUD:     rdata_d = {13'h0000, baud_q};
        `CSC_REG_STATUS:   rdata_d = {7'h00, reject_q, 3'h0, cmd_q};
        `CSC_REG_WORD_CNT: rdata_d = word_cnt_q;
        `CSC_REG_DROP_CNT: rdata_d = drop_cnt_q;
        default:           rdata_d = 16'h0000;
      endcase
    end
  end

  // Read data stand one cycle after the strobe only
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_rdata_out <= rdata_d;
    end
  end

endmodule // csc_combiner

`default_nettype wire

// ===== csc_defines.vh
// Constants for the command source combiner
`ifndef CSC_DEFINES_VH
`define CSC_DEFINES_VH

// Register indices on the local port
`define CSC_ADDR_W          4
`define CSC_REG_SRC_SEL     4'h0
`define CSC_REG_CTL_WORD    4'h1
`define CSC_REG_BAUD        4'h2
`define CSC_REG_STATUS      4'h3
`define CSC_REG_WORD_CNT    4'h4
`define CSC_REG_DROP_CNT    4'h5

// Source selector encodings
`define CSC_SRC_TERM        2'h0
`define CSC_SRC_SERIAL      2'h1
`define CSC_SRC_AND         2'h2
`define CSC_SRC_OR          2'h3
`define CSC_SRC_SEL_RST     10'h3FF

// Command slots, also selector field index (2 bits each)
`define CSC_NUM_CMD         5
`define CSC_CMD_COAST       0
`define CSC_CMD_QSTOP       1
`define CSC_CMD_DCBRAKE     2
`define CSC_CMD_START       3
`define CSC_CMD_REVERSE     4
// Active-low mask per command slot
`define CSC_ACT_LOW_MASK    5'h07

// Serial control word bit positions
`define CSC_CW_DCBRAKE_BIT  2
`define CSC_CW_COAST_BIT    3
`define CSC_CW_QSTOP_BIT    4
`define CSC_CW_START_BIT    6
`define CSC_CW_VALID_BIT    10
`define CSC_CW_REVERSE_BIT  15
// Word reset: active-low bits high, active-high bits low
`define CSC_CW_RST          16'h001C

// Bit-rate selection
`define CSC_BAUD_W          3
`define CSC_BAUD_RST        3'h5
`define CSC_BAUD_MAX        3'h5

// Status fields
`define CSC_ST_REJECT_BIT   8

`endif

// ===== csc_master_model.sv
// Serial bus master model feeding control words
`timescale 1ns/100ps
`default_nettype none
module csc_master_model (
  // Clock and request from the bench
  input  wire logic        clk_in,
  input  wire logic        send_in,
  input  wire logic [15:0] word_in,
  // Link towards the device, same bit rate assumed
  output var  logic [15:0] ser_word_out = 16'h0000,
  output var  logic        ser_word_stb_out = 1'b0
);
  // Idle line toggles so a stale word never looks fresh
  always @(posedge clk_in) begin
    ser_word_stb_out <= send_in;
    ser_word_out     <= send_in ? word_in : ~ser_word_out;
  end
endmodule // csc_master_model
`default_nettype wire

// ===== csc_source_mux.v
// One command's source combiner, combinational
`timescale 1ns/100ps
`default_nettype none

module csc_source_mux #(
  parameter ACT_LOW = 1'b0
) (
  // Selection
  input  wire [1:0] sel_in,
  // Sources, in their own polarity
  input  wire       term_in,
  input  wire       ser_in,
  // Resolved request, active high
  output reg        req_out
);

`include "csc_defines.vh"

  wire term_req;
  wire ser_req;

  // Combine on the asserted level, so AND/OR act on requests
  assign term_req = term_in ^ ACT_LOW;
  assign ser_req  = ser_in ^ ACT_LOW;

  always @* begin
    case (sel_in)
      `CSC_SRC_TERM:   req_out = term_req;
      `CSC_SRC_SERIAL: req_out = ser_req;
      `CSC_SRC_AND:    req_out = term_req & ser_req;
      `CSC_SRC_OR:     req_out = term_req | ser_req;
      default:         req_out = term_req | ser_req;
    endcase
  end

endmodule // csc_source_mux

`default_nettype wire

// ===== tb_top.sv
// Random and corner-case bench for the command source combiner
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk_in = 1'b0, reset_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic        ser_baud_wr_in = 1'b0, send = 1'b0, ser_word_stb_in;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000, word = 16'h0000, cw = 16'h001C;
  logic [15:0] reg_rdata_out, ser_word_in;
  logic [4:0]  term = 5'h1F, outs, exp_cmd = 5'h00;
  logic [2:0]  baud_sel_out;
  logic [31:0] rnd;
  integer      err_count = 0, tests_run = 0, seed = 32'hEA7D, i;
  csc_master_model i_csc_master_model (.clk_in, .send_in(send), .word_in(word),
    .ser_word_out(ser_word_in), .ser_word_stb_out(ser_word_stb_in));
  csc_combiner i_csc_combiner (.clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .ser_word_in, .ser_word_stb_in, .ser_baud_wr_in,
    .term_coast_n_in(term[0]), .term_qstop_n_in(term[1]), .term_dcbrake_n_in(term[2]),
    .term_start_in(term[3]), .term_reverse_in(term[4]), .coast_req_out(outs[0]),
    .qstop_req_out(outs[1]), .dcbrake_req_out(outs[2]), .start_req_out(outs[3]),
    .reverse_req_out(outs[4]), .baud_sel_out);
  always #2.5 clk_in = ~clk_in;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  // Reads carry their expected value on the data argument
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= w;
    reg_rd_in    <= !w;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1 if (!w) chk(reg_rdata_out, d);
  endtask
  function automatic logic [4:0] want(input logic [9:0] s, input logic [4:0] t,
                                      input logic [15:0] w);
    logic [4:0] a;
    logic [4:0] b;
    a = t ^ 5'h07;
    b = {w[15], w[6], w[2], w[4], w[3]} ^ 5'h07;
    for (int k = 0; k < 5; k++)
      want[k] = s[2*k+1] ? (s[2*k] ? a[k] | b[k] : a[k] & b[k]) : (s[2*k] ? b[k] : a[k]);
  endfunction
  task automatic apply(input logic [9:0] s, input logic [4:0] t, input logic [15:0] w);
    bus(1'b1, 4'h0, {6'h00, s});
    @(posedge clk_in);
    term <= t;
    word <= w;
    send <= 1'b1;
    @(posedge clk_in);
    send <= 1'b0;
    if (w[10]) cw = w;
    exp_cmd = want(s, t, cw);
    repeat (3) @(posedge clk_in);
    #1 chk({11'h000, outs}, {11'h000, want(s, t, cw)});
    bus(1'b0, 4'h1, cw);
  endtask
  task automatic complete_run;
    $display("checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    bus(1'b0, 4'h0, 16'h03FF);
    // Every mode against every input pair, then random traffic
    for (i = 0; i < 16; i++)
      apply({5{i[3:2]}}, {5{i[1]}}, i[0] ? 16'hFFFF : 16'h0400);
    for (i = 0; i < 40; i++) begin
      rnd = $random(seed);
      apply(rnd[9:0], rnd[14:10], rnd[31:16]);
    end
    bus(1'b1, 4'h2, 16'h0003);
    @(posedge clk_in);
    ser_baud_wr_in <= 1'b1;
    @(posedge clk_in);
    ser_baud_wr_in <= 1'b0;
    bus(1'b0, 4'h2, 16'h0003);
    chk({13'h0000, baud_sel_out}, 16'h0003);
    bus(1'b0, 4'h3, {7'h00, 1'b1, 3'h0, exp_cmd});
    bus(1'b1, 4'h3, 16'h0100);
    bus(1'b0, 4'h3, {7'h00, 1'b0, 3'h0, exp_cmd});
    bus(1'b0, 4'hF, 16'h0000);
    // Mid-run reset must restore the inactive serial word and OR selectors
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    cw = 16'h001C;
    bus(1'b0, 4'h1, cw);
    bus(1'b0, 4'h0, 16'h03FF);
    chk({13'h0000, baud_sel_out}, 16'h0005);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
